/* File: sync_latch_event_mask_cfg_defines.svh */
/*
 * Offsets, field positions, reset values and codes of the sync/latch,
 * extended I/O and event mask register group.
 * Assumes byte-wide access from both sides and a single clock.
 */
`ifndef SYNC_LATCH_EVENT_MASK_CFG_DEFINES_SVH
`define SYNC_LATCH_EVENT_MASK_CFG_DEFINES_SVH

// Byte addresses of the group
`define SLC_OFF          16'h0151
`define EXT_LO_OFF       16'h0152
`define EXT_HI_OFF       16'h0153
`define NET_MASK_OFF     16'h0200
`define APP_MASK_OFF     16'h0204
`define SECOND_SYNC_STAT_OFF 16'h098F

// Fields of the sync/latch configuration byte
`define SLC_MAP1_BIT     7
`define SLC_MODE1_BIT    6
`define SLC_DRV1_LSB     4
`define SLC_MAP0_BIT     3
`define SLC_MODE0_BIT    2
`define SLC_DRV0_LSB     0

// Bits of the application event request word fed by the sync signals
`define APP_REQ_SECOND_BIT 3
`define APP_REQ_FIRST_BIT  2

// Reset values
`define SLC_RESET        8'h00
`define EXT_RESET        16'h0000
`define NET_MASK_RESET   16'h0000
`define APP_MASK_RESET   32'h00FFFF0F

// Sync output driver codes
`define DRV_PP_LOW       2'h0
`define DRV_OD_LOW       2'h1
`define DRV_PP_HIGH      2'h2
`define DRV_OS_HIGH      2'h3

`endif

/* File: sync_latch_event_mask_cfg_pkg.sv */
/*
 * Types shared by the sync/latch and event mask register group.
 * Assumes the defines header is compiled alongside.
 */
package sync_latch_event_mask_cfg_pkg;

	// One byte access from either side
	typedef struct packed {
		logic        rd;    // Read strobe
		logic        wr;    // Write strobe
		logic [15:0] addr;  // Byte address
		logic [7:0]  wdata; // Write byte
	} acc_req_t;

	// Read answer, one cycle after the strobe
	typedef struct packed {
		logic       rvalid; // Answer valid
		logic [7:0] rdata;  // Read byte
	} acc_rsp_t;

	// Drive of a shared two-way pin
	typedef struct packed {
		logic out; // Level driven
		logic oe;  // High while driving
	} pin_drive_t;

endpackage : sync_latch_event_mask_cfg_pkg

/* File: sync_latch_event_mask_cfg.sv */
/*
 * Sync/latch pin configuration, extended I/O configuration and the two
 * event masks, with the event gating they steer.
 * Assumes both access sides and the event sources run on mclk_i; the
 * shared pins come from outside and are synchronised here.
 */
`include "sync_latch_event_mask_cfg_defines.svh"

module sync_latch_event_mask_cfg
	import sync_latch_event_mask_cfg_pkg::*;
(
	input  wire logic        mclk_i,            // 25 MHz clock
	input  wire logic        rst_i,             // Synchronous reset, active high
	input  wire acc_req_t    net_req_i,         // Network side access
	output acc_rsp_t         net_rsp_o,         // Network side answer
	input  wire acc_req_t    host_req_i,        // Host interface access
	output acc_rsp_t         host_rsp_o,        // Host interface answer
	input  wire logic        cfg_load_i,        // Start-up configuration load pulse
	input  wire logic [7:0]  cfg_slc_i,         // Loaded sync/latch byte
	input  wire logic [15:0] cfg_ext_i,         // Loaded extended config word
	input  wire logic        mode_dio_i,        // 1 digital I/O, 0 serial interface
	input  wire logic        bidir_opt_i,       // Bidirectional option bit
	input  wire logic        first_sync_i,      // First sync signal
	input  wire logic        second_sync_i,     // Second sync signal
	input  wire logic        first_pin_i,       // First shared pin level
	input  wire logic        second_pin_i,      // Second shared pin level
	output pin_drive_t       first_pin_o,       // First shared pin drive
	output pin_drive_t       second_pin_o,      // Second shared pin drive
	output logic             first_latch_o,     // Synchronised first latch input
	output logic             second_latch_o,    // Synchronised second latch input
	input  wire logic [31:0] app_event_src_i,   // Other application event requests
	input  wire logic [15:0] net_event_req_i,   // Network event requests
	output logic [15:0]      net_event_o,       // Masked events for frames
	output logic [31:0]      app_event_req_o,   // Application event request word
	output logic             host_irq_o,        // Host interrupt line, active high
	output logic [15:0]      io_dir_o,          // Per-pin direction, 1 output
	output logic [15:0]      io_open_drain_o,   // Per-pin buffer, 1 open drain
	output logic             io_bidir_o         // All I/O bidirectional
);

	logic [7:0]  slc_cfg;        // Sync/latch configuration byte
	logic [15:0] ext_cfg;        // Extended configuration word
	logic [15:0] net_mask;       // Network event mask
	logic [31:0] app_mask;       // Application event mask
	logic        second_sync_q;  // Previous second sync level
	logic        second_evt;     // Sticky mapped second sync
	logic [1:0]  pin0_sync;      // First pin synchroniser
	logic [1:0]  pin1_sync;      // Second pin synchroniser
	logic [31:0] next_req;       // Request word being formed
	logic        bidir_act;      // Bidirectional mode in force
	logic        second_clr;     // Status read seen on either side
	logic        second_set;     // Mapped second sync rising edge

	// Read value of one byte address, low byte at the low address
	function automatic logic [7:0] read_byte(input logic [15:0] a);
		logic [15:0] ext_vis;
		ext_vis = ext_cfg;
		if (mode_dio_i) begin
			ext_vis[15:8] = 8'h00;
			if (bidir_act) begin
				ext_vis[7:0] = 8'h00;
			end
		end
		read_byte = 8'h00;                            // Unmapped reads zero
		case (a)
			`SLC_OFF:              read_byte = slc_cfg;
			`EXT_LO_OFF:           read_byte = ext_vis[7:0];
			`EXT_HI_OFF:           read_byte = ext_vis[15:8];
			`NET_MASK_OFF:         read_byte = net_mask[7:0];
			`NET_MASK_OFF + 16'h1: read_byte = net_mask[15:8];
			`APP_MASK_OFF:         read_byte = app_mask[7:0];
			`APP_MASK_OFF + 16'h1: read_byte = app_mask[15:8];
			`APP_MASK_OFF + 16'h2: read_byte = app_mask[23:16];
			`APP_MASK_OFF + 16'h3: read_byte = app_mask[31:24];
			default:               read_byte = 8'h00;
		endcase
	endfunction : read_byte

	// Pin drive for one shared pin from its mode bit and driver code
	function automatic pin_drive_t drive_pin(input logic is_out,
	                                         input logic [1:0] code,
	                                         input logic level);
		drive_pin = '0;
		if (is_out) begin
			case (code)
				`DRV_PP_LOW:  drive_pin = '{out: ~level, oe: 1'b1};
				`DRV_OD_LOW:  drive_pin = '{out: 1'b0,   oe: level};
				`DRV_PP_HIGH: drive_pin = '{out: level,  oe: 1'b1};
				`DRV_OS_HIGH: drive_pin = '{out: 1'b1,   oe: level};
				default:      drive_pin = '0;
			endcase
		end
	endfunction : drive_pin

	// Bidirectional option only counts in digital I/O mode
	assign bidir_act = mode_dio_i & bidir_opt_i;
	assign second_clr = (net_req_i.rd && net_req_i.addr == `SECOND_SYNC_STAT_OFF) ||
	                    (host_req_i.rd && host_req_i.addr == `SECOND_SYNC_STAT_OFF);
	assign second_set = slc_cfg[`SLC_MAP1_BIT] & second_sync_i & ~second_sync_q;

	// Configuration fields: no side writes them, only the start-up load
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			slc_cfg <= `SLC_RESET;
			ext_cfg <= `EXT_RESET;
		end else if (cfg_load_i) begin
			slc_cfg <= cfg_slc_i;
			ext_cfg <= cfg_ext_i;
		end
	end

	// Network mask: byte writes from the network side only
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			net_mask <= `NET_MASK_RESET;
		end else if (net_req_i.wr) begin
			if (net_req_i.addr == `NET_MASK_OFF) begin
				net_mask[7:0] <= net_req_i.wdata;
			end else if (net_req_i.addr == `NET_MASK_OFF + 16'h1) begin
				net_mask[15:8] <= net_req_i.wdata;
			end
		end
	end

	// Application mask: byte writes from the host only
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			app_mask <= `APP_MASK_RESET;
		end else if (host_req_i.wr) begin
			case (host_req_i.addr)
				`APP_MASK_OFF:         app_mask[7:0]   <= host_req_i.wdata;
				`APP_MASK_OFF + 16'h1: app_mask[15:8]  <= host_req_i.wdata;
				`APP_MASK_OFF + 16'h2: app_mask[23:16] <= host_req_i.wdata;
				`APP_MASK_OFF + 16'h3: app_mask[31:24] <= host_req_i.wdata;
				default:               app_mask        <= app_mask;
			endcase
		end
	end

	// Read answers, one cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			net_rsp_o  <= '0;
			host_rsp_o <= '0;
		end else begin
			net_rsp_o.rvalid  <= net_req_i.rd;
			net_rsp_o.rdata   <= net_req_i.rd ? read_byte(net_req_i.addr) : 8'h00;
			host_rsp_o.rvalid <= host_req_i.rd;
			host_rsp_o.rdata  <= host_req_i.rd ? read_byte(host_req_i.addr) : 8'h00;
		end
	end

	// Second sync event: sticky, set beats a same-cycle status read
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			second_sync_q <= 1'b0;
			second_evt    <= 1'b0;
		end else begin
			second_sync_q <= second_sync_i;
			if (second_set) begin
				second_evt <= 1'b1;
			end else if (second_clr) begin
				second_evt <= 1'b0;
			end
		end
	end

	// Request word with the sync bits put in their slots
	always_comb begin
		next_req = app_event_src_i;
		next_req[`APP_REQ_SECOND_BIT] = second_evt;
		next_req[`APP_REQ_FIRST_BIT] = slc_cfg[`SLC_MAP0_BIT] & first_sync_i;
	end

	// Event gating toward frames and host interrupt
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			app_event_req_o <= 32'h00000000;
			host_irq_o      <= 1'b0;
			net_event_o     <= 16'h0000;
		end else begin
			app_event_req_o <= next_req;
			host_irq_o      <= |(next_req & app_mask);
			net_event_o     <= net_event_req_i & net_mask;
		end
	end

	// Shared pins: outside levels pass two flops before use
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pin0_sync      <= 2'h0;
			pin1_sync      <= 2'h0;
			first_latch_o  <= 1'b0;
			second_latch_o <= 1'b0;
		end else begin
			pin0_sync      <= {pin0_sync[0], first_pin_i};
			pin1_sync      <= {pin1_sync[0], second_pin_i};
			// Latch input seen only while the pin is not a sync output
			first_latch_o  <= ~slc_cfg[`SLC_MODE0_BIT] & pin0_sync[1];
			second_latch_o <= ~slc_cfg[`SLC_MODE1_BIT] & pin1_sync[1];
		end
	end

	// Shared pin drivers; released while acting as latch inputs
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			first_pin_o  <= '0;
			second_pin_o <= '0;
		end else begin
			first_pin_o  <= drive_pin(slc_cfg[`SLC_MODE0_BIT],
			                          slc_cfg[`SLC_DRV0_LSB +: 2], first_sync_i);
			second_pin_o <= drive_pin(slc_cfg[`SLC_MODE1_BIT],
			                          slc_cfg[`SLC_DRV1_LSB +: 2], second_sync_i);
		end
	end

	// I/O pair setup; layout depends on interface mode
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			io_dir_o        <= 16'h0000;
			io_open_drain_o <= 16'h0000;
			io_bidir_o      <= 1'b0;
		end else begin
			io_bidir_o <= bidir_act;
			for (int k = 0; k < 8; k++) begin
				// Each direction bit covers one pin pair
				io_dir_o[2*k +: 2] <= {2{ext_cfg[k] & ~bidir_act}};
				// Buffer types exist only in the serial layout
				io_open_drain_o[2*k +: 2] <= {2{ext_cfg[8+k] & ~mode_dio_i}};
			end
		end
	end

	a_second_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		second_evt && !second_clr |=> second_evt)
		else $error("mapped second sync bit lost without a status read");

	a_second_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
		second_clr && !second_set |=> ##1 !app_event_req_o[`APP_REQ_SECOND_BIT])
		else $error("second sync bit not cleared by status read");

	a_first_map: assert property (@(posedge mclk_i) disable iff (rst_i)
		app_event_req_o[`APP_REQ_FIRST_BIT] ==
		$past(slc_cfg[`SLC_MAP0_BIT] & first_sync_i))
		else $error("first sync bit not following its mapping");

	a_latch_pin_free: assert property (@(posedge mclk_i) disable iff (rst_i)
		!slc_cfg[`SLC_MODE1_BIT] ##1 !slc_cfg[`SLC_MODE1_BIT] |-> !second_pin_o.oe)
		else $error("second pin driven while a latch input");

	a_open_drain_low: assert property (@(posedge mclk_i) disable iff (rst_i)
		slc_cfg[`SLC_MODE0_BIT] && slc_cfg[1:0] == `DRV_OD_LOW |=>
		!first_pin_o.out && first_pin_o.oe == $past(first_sync_i))
		else $error("open drain first pin drives wrong level");

	a_net_mask_host_ro: assert property (@(posedge mclk_i) disable iff (rst_i)
		host_req_i.wr && !net_req_i.wr |=> $stable(net_mask))
		else $error("host write changed network mask");

	a_app_mask_net_ro: assert property (@(posedge mclk_i) disable iff (rst_i)
		net_req_i.wr && !host_req_i.wr |=> $stable(app_mask))
		else $error("network write changed application mask");

	a_ext_high_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		host_req_i.rd && host_req_i.addr == `EXT_HI_OFF && mode_dio_i |=>
		host_rsp_o.rvalid && host_rsp_o.rdata == 8'h00)
		else $error("reserved extended byte not zero in digital mode");

	a_irq_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		(app_mask == 32'h00000000)[*2] |-> !host_irq_o)
		else $error("interrupt raised with every request masked");

	a_net_event_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> net_event_o == ($past(net_event_req_i) & $past(net_mask)))
		else $error("network event not gated by its mask");

endmodule : sync_latch_event_mask_cfg

/* File: pdi_host_model.sv */
/*
 * Behavioural local host controller on the process data interface:
 * one byte read or write at a time, through tasks.
 * Assumes the block answers a read exactly one cycle after the strobe.
 */
module local_host_model
	import sync_latch_event_mask_cfg_pkg::*;
(
	input  wire logic     mclk_i, // Shared clock
	output acc_req_t      req_o,  // Access towards the block
	input  wire acc_rsp_t rsp_i   // Answer from the block
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at start
	initial begin
		req_o = '0;
	end

	// Byte write; the host only writes its own mask bytes in earnest
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk_i);
		#1;
		// Released lines show the inverse, not the stale value
		req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr

	// Byte read; the network mask is only read from here
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
		@(posedge mclk_i);
		#1;
		req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge mclk_i);
		#1;
		// Answer stands through the cycle after the taking edge
		d = rsp_i.rdata;
		ok = rsp_i.rvalid;
		req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
	endtask : rd

endmodule : local_host_model

/* File: sync_latch_event_mask_cfg_tb_top.sv */
/*
 * Self-checking bench of the sync/latch and event mask register group.
 * Assumes the host model and the defines header are compiled before it.
 */
`include "sync_latch_event_mask_cfg_defines.svh"
module sync_latch_event_mask_cfg_tb_top
	import sync_latch_event_mask_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk_i, rst_i, cfg_load, mode_dio, bidir, sync_a, sync_b, pin_a, pin_b;
	acc_req_t    net_req, host_req;   // Both access sides
	acc_rsp_t    net_rsp, host_rsp;   // Their answers
	logic [7:0]  cfg_slc;             // Loaded config byte
	logic [15:0] cfg_ext, net_ev_req, net_ev, io_dir, io_od;
	logic [31:0] app_src, app_req;    // Event words
	pin_drive_t  drv_a, drv_b;        // Shared pin drives
	logic        latch_a, latch_b, irq, io_bidir;
	int          miscompares = 0;
	int          cmp_count = 0;

	sync_latch_event_mask_cfg dut (.mclk_i(mclk_i), .rst_i(rst_i), .net_req_i(net_req),
		.net_rsp_o(net_rsp), .host_req_i(host_req), .host_rsp_o(host_rsp),
		.cfg_load_i(cfg_load), .cfg_slc_i(cfg_slc), .cfg_ext_i(cfg_ext),
		.mode_dio_i(mode_dio), .bidir_opt_i(bidir), .first_sync_i(sync_a),
		.second_sync_i(sync_b), .first_pin_i(pin_a), .second_pin_i(pin_b),
		.first_pin_o(drv_a), .second_pin_o(drv_b), .first_latch_o(latch_a),
		.second_latch_o(latch_b), .app_event_src_i(app_src), .net_event_req_i(net_ev_req),
		.net_event_o(net_ev), .app_event_req_o(app_req), .host_irq_o(irq),
		.io_dir_o(io_dir), .io_open_drain_o(io_od), .io_bidir_o(io_bidir));
	local_host_model host (.mclk_i(mclk_i), .req_o(host_req), .rsp_i(host_rsp));
	local_host_model net_side (.mclk_i(mclk_i), .req_o(net_req), .rsp_i(net_rsp));

	// 25 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// One compare for every kind of result; unknowns never match
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Read a byte from one side and compare valid plus data
	task automatic rdc(input bit from_net, input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		if (from_net) net_side.rd(a, d, ok);
		else host.rd(a, d, ok);
		chk($sformatf("read %h", a), {23'h0, 1'b1, e}, {23'h0, ok, d});
	endtask : rdc

	// Let registered outputs settle, then sit just past an edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : tick

	// Start-up configuration load pulse
	task automatic load(input logic [7:0] s, input logic [15:0] e);
		@(posedge mclk_i);
		#1;
		cfg_slc = s;
		cfg_ext = e;
		cfg_load = 1'b1;
		@(posedge mclk_i);
		#1;
		cfg_load = 1'b0;
	endtask : load

	// Pair bits widened to per-pin bits
	function automatic logic [15:0] widen(input logic [7:0] p);
		for (int k = 0; k < 8; k++) widen[2*k+:2] = {2{p[k]}};
	endfunction : widen

	// Expected {out, oe} of a sync output for a driver code and sync level
	function automatic logic [1:0] drv_exp(input logic [1:0] c, input logic s);
		case (c)
			2'h0:    drv_exp = {~s, 1'b1};  // Push-pull, active low
			2'h1:    drv_exp = {1'b0, s};   // Open drain pulls low when active
			2'h2:    drv_exp = {s, 1'b1};   // Push-pull, active high
			default: drv_exp = {1'b1, s};   // Open source drives high when active
		endcase
	endfunction : drv_exp

	// Reset values of the masks, byte order and an idle interrupt line
	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			rdc(1, 16'h0204 + 16'(i), 8'(`APP_MASK_RESET >> (8*i)));
		end
		rdc(0, 16'h0200, 8'h00);
		rdc(0, 16'h0201, 8'h00);
		chk("irq idle", 32'h0, {31'h0, irq});
	endtask : t_reset

	// Sync mapping on and off, sticky second sync and its clearing read
	task automatic t_sync;
		load(8'h88, 16'h0000);
		sync_a = 1'b1;
		tick(3);
		chk("first sync map", 32'h4, app_req & 32'hC);
		sync_a = 1'b0;
		sync_b = 1'b1;
		tick(3);
		chk("second sync map", 32'h8, app_req & 32'hC);
		chk("irq on sync", 32'h1, {31'h0, irq});
		sync_b = 1'b0;
		tick(3);
		chk("second sync sticky", 32'h8, app_req & 32'hC);
		rdc(0, 16'h098F, 8'h00);
		tick(2);
		chk("second sync cleared", 32'h0, app_req & 32'hC);
		load(8'h00, 16'h0000);
		sync_a = 1'b1;
		sync_b = 1'b1;
		tick(3);
		chk("sync unmapped", 32'h0, app_req & 32'hC);
		sync_a = 1'b0;
		sync_b = 1'b0;
	endtask : t_sync

	// Side ownership of both masks and the gating they steer
	task automatic t_masks;
		net_side.wr(16'h0200, 8'hA5);
		net_side.wr(16'h0201, 8'h3C);
		host.wr(16'h0200, 8'hFF);
		rdc(0, 16'h0200, 8'hA5);
		rdc(0, 16'h0201, 8'h3C);
		net_ev_req = 16'hFFFF;
		tick(2);
		chk("net events", 32'h3CA5, {16'h0, net_ev});
		for (int i = 0; i < 4; i++) begin
			host.wr(16'h0204 + 16'(i), 8'(32'h00000100 >> (8*i)));
		end
		net_side.wr(16'h0204, 8'hFF);
		rdc(1, 16'h0204, 8'h00);
		rdc(1, 16'h0205, 8'h01);
		app_src = 32'h00000100;
		tick(3);
		chk("irq masked in", 32'h1, {31'h0, irq});
		app_src = 32'h00000200;
		tick(3);
		chk("irq masked out", 32'h0, {31'h0, irq});
		// Whole mask cleared: nothing may reach the line, sync slots stay replaced
		host.wr(16'h0205, 8'h00);
		app_src = 32'hFFFFFFFF;
		tick(3);
		chk("irq all masked", 32'h0, {31'h0, irq});
		chk("request word", 32'hFFFFFFF3, app_req);
		app_src = 32'h00000000;
	endtask : t_masks

	// Every driver code on both pins, then latch mode and read-only config
	task automatic t_pins;
		for (int c = 0; c < 4; c++) begin
			load({1'b0, 1'b1, 2'(c), 1'b0, 1'b1, 2'(c)}, 16'h0000);
			for (int s = 0; s < 2; s++) begin
				sync_a = 1'(s);
				sync_b = ~1'(s);
				tick(3);
				chk("first pin", {30'h0, drv_exp(2'(c), 1'(s))}, {30'h0, drv_a});
				chk("second pin", {30'h0, drv_exp(2'(c), ~1'(s))}, {30'h0, drv_b});
			end
		end
		rdc(1, 16'h0151, 8'h77);
		host.wr(16'h0151, 8'h00);
		rdc(0, 16'h0151, 8'h77);
		load(8'h00, 16'h0000);
		pin_a = 1'b1;
		tick(4);
		chk("latch inputs", 32'h2, {30'h0, latch_a, latch_b});
		chk("pins released", 32'h0, {30'h0, drv_a.oe, drv_b.oe});
		pin_a = 1'b0;
		pin_b = 1'b1;
		tick(4);
		chk("latch swapped", 32'h1, {30'h0, latch_a, latch_b});
	endtask : t_pins

	// Extended config in serial, digital and bidirectional modes
	task automatic t_ext;
		load(8'h00, 16'hA55A);
		mode_dio = 1'b0;
		bidir = 1'b1;
		tick(3);
		rdc(1, 16'h0152, 8'h5A);
		rdc(0, 16'h0153, 8'hA5);
		chk("serial dir", {16'h0, widen(8'h5A)}, {16'h0, io_dir});
		chk("serial buffers", {16'h0, widen(8'hA5)}, {16'h0, io_od});
		mode_dio = 1'b1;
		bidir = 1'b0;
		tick(3);
		rdc(0, 16'h0153, 8'h00);
		rdc(1, 16'h0152, 8'h5A);
		chk("digital dir", {16'h0, widen(8'h5A)}, {16'h0, io_dir});
		chk("digital buffers", 32'h0, {16'h0, io_od});
		bidir = 1'b1;
		tick(3);
		rdc(1, 16'h0152, 8'h00);
		chk("bidir dir", 32'h1, {io_dir, 15'h0, io_bidir});
	endtask : t_ext

	// Verdict, reached from the main sequence or the watchdog
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results

	// Reset for ten cycles, then every scenario in turn
	initial begin
		{rst_i, cfg_load, mode_dio, bidir, sync_a, sync_b, pin_a, pin_b} = 8'h80;
		{cfg_slc, cfg_ext, net_ev_req, app_src} = '0;
		repeat (10) @(posedge mclk_i);
		#1;
		rst_i = 1'b0;
		t_reset();
		t_sync();
		t_masks();
		t_pins();
		t_ext();
		results();
	end

	// Watchdog against a hang
	initial begin
		#400000;
		miscompares++;
		results();
	end

endmodule : sync_latch_event_mask_cfg_tb_top
